// ### rtl/serial_tail_pkg.sv
package serial_tail_pkg;

   // Control word as software writes it
   typedef struct packed {
      logic       mode_high_bit;
      logic       mode_low_bit;     // 0: 8-bit word, 1: 16-bit word
      logic       tail_mark_enable;
      logic       latch_select_bit; // 0: hold-type tail, 1: latch-type tail
      logic [3:0] clock_select;     // msb set: external clock
   } ctrl_t;

   // Status word seen by software
   typedef struct packed {
      logic output_level_bit;
      logic overrun_error_flag;
      logic tail_active_flag;
      logic start_flag;
   } stat_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SHIFT = 2'b01,
      ST_TAIL  = 2'b11
   } state_t;

   localparam int          PRESC_W      = 10;
   localparam int          CLK_SEL_MSB  = 3;
   localparam logic [4:0]  BITS_8       = 5'h08;
   localparam logic [4:0]  BITS_16      = 5'h10;
   localparam logic [3:0]  TAIL_HOLD_HP = 4'h2;
   localparam logic [3:0]  TAIL_LATCH_SELECT_BIT_HP = 4'h4;
   localparam logic [7:0]  DATA_RST     = 8'h00;
   localparam logic        LEVEL_RST    = 1'b0;
   localparam logic [PRESC_W-1:0] TAP_MASK [0:7] = '{
      10'h000, 10'h001, 10'h003, 10'h007,
      10'h00F, 10'h01F, 10'h07F, 10'h1FF
   };

endpackage

// ### rtl/sync_serial_tail_mark_port.sv
`timescale 1ns/10ps
// Contract
// - Control write with tail off resets unit
// - Plain transfers; mode-low picks 8/16 bits
// - Low byte in low reg, high in high
// - Start write begins transfer only while mode-high is clear, drives output
// - Every completion sets done request
// - Internal clock pulses only during word
// - Output holds last bit after a plain transfer, ends high after a tail
// - External clock shifts; late edges flag overrun
// - Idle level write changes output pin
// - Send and receive together, then done
// - Tail mark follows each word when enabled
// - Latch-select picks hold or latch tail
// - Tail timing uses internal tap period, even with external clock
// - Tail mode: clear start, request, tail
// - Interrupt only when enable permits
// - Clock from eight taps or external pin
// - Tail mode data goes LSB first
// - Start flag is busy indicator
// - Change on falling, sample on rising
// - Overrun clears by zero write after read
module sync_serial_tail_mark_port
   import serial_tail_pkg::*;
(
   input  wire logic       CLK_SYS,      // System clock
   input  wire logic       SRST,         // Sync reset
   input  wire logic       CE,           // Clock enable
   input  wire logic       CTRL_WR,      // Control write strobe
   input  wire ctrl_t      CTRL_IN,      // Control write data
   input  wire logic       DATA_WR,      // Data regs write strobe
   input  wire logic [7:0] DATA_LOW_IN,  // Low data byte
   input  wire logic [7:0] DATA_HIGH_IN, // High data byte
   input  wire logic       START_WR,     // Write 1 to start flag
   input  wire logic       LEVEL_WR,     // Output level write
   input  wire logic       LEVEL_IN,     // Output level value
   input  wire logic       STATUS_RD,    // Status read strobe
   input  wire logic       OVR_CLR_WR,   // Write 0 to overrun
   input  wire logic       DONE_CLR,     // Clear done request
   input  wire logic       DONE_EN,      // Done interrupt enable
   input  wire logic       OD_SEL,       // Open-drain select
   input  wire logic       SCK_IN,       // Clock pin input
   output logic            SCK_OUT,      // Clock pin output
   output logic            SCK_OE,       // Clock pin enable
   input  wire logic       SI_IN,        // Serial input pin
   output logic            SO_OUT,       // Serial output pin
   output logic            SO_OE,        // Serial output enable
   output ctrl_t           CTRL_OUT,     // Control readback
   output stat_t           STATUS,       // Status readback
   output logic [7:0]      DATA_LOW_OUT, // Low data readback
   output logic [7:0]      DATA_HIGH_OUT,// High data readback
   output logic            DONE_REQ,     // Done request flag
   output logic            DONE_IRQ      // Gated interrupt
);

   ctrl_t              ctrl_r;
   state_t             state_r;
   logic [PRESC_W-1:0] presc_r;
   logic [15:0]        sh_r;
   logic [7:0]         dlo_r;
   logic [7:0]         dhi_r;
   logic [4:0]         bits_r;
   logic [3:0]         tail_cnt_r;
   logic               sck_r;
   logic               so_r;
   logic               start_r;
   logic               tail_r;
   logic               req_r;
   logic               ovr_r;
   logic               ovr_armed_r;
   logic               done_once_r;
   logic               sck_m_r;
   logic               sck_s_r;
   logic               sck_d_r;
   logic               si_m_r;
   logic               si_s_r;

   logic               ext_clk;
   logic               tick;
   logic               ext_rise;
   logic               ext_fall;
   logic               fall_ev;
   logic               rise_ev;
   logic               init;
   logic               go;
   logic               last_bit;
   logic               word_done;
   logic               tail_end;
   logic [4:0]         word_bits;
   logic [3:0]         tail_len;

   assign ext_clk   = ctrl_r.clock_select[CLK_SEL_MSB];
   assign tick      = &(presc_r
                        | ~TAP_MASK[ctrl_r.clock_select[2:0]]);
   assign ext_rise  = sck_s_r & ~sck_d_r;
   assign ext_fall  = ~sck_s_r & sck_d_r;
   assign fall_ev   = ext_clk ? ext_fall : (tick & sck_r);
   assign rise_ev   = ext_clk ? ext_rise : (tick & ~sck_r);
   assign init      = CTRL_WR & ~CTRL_IN.tail_mark_enable;
   assign word_bits = ctrl_r.mode_low_bit ? BITS_16 : BITS_8;
   assign last_bit  = (bits_r == word_bits - 5'h01);
   assign word_done = (state_r == ST_SHIFT) & rise_ev & last_bit;
   assign tail_len  = ctrl_r.latch_select_bit ? TAIL_LATCH_SELECT_BIT_HP
                                              : TAIL_HOLD_HP;
   assign tail_end  = (state_r == ST_TAIL) & tick
                      & (tail_cnt_r == tail_len);
   assign go        = START_WR & (state_r == ST_IDLE)
                      & ~ctrl_r.mode_high_bit & ~init;

   // Pin synchronisers
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
      begin
         sck_m_r <= 1'b1;
         sck_s_r <= 1'b1;
         sck_d_r <= 1'b1;
         si_m_r  <= 1'b0;
         si_s_r  <= 1'b0;
      end
      else if (CE)
      begin
         sck_m_r <= SCK_IN;
         sck_s_r <= sck_m_r;
         sck_d_r <= sck_s_r;
         si_m_r  <= SI_IN;
         si_s_r  <= si_m_r;
      end
   end

   // Prescaler, cleared at start, taps selected by clock field
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST || (CE && go))
         presc_r <= '0;
      else if (CE)
         presc_r <= presc_r + 1'b1;
   end

   // Control register
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
         ctrl_r <= '0;
      else if (CE && CTRL_WR)
         ctrl_r <= CTRL_IN;
   end

   // Sequencer
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
      begin
         state_r    <= ST_IDLE;
         bits_r     <= '0;
         tail_cnt_r <= '0;
         start_r    <= 1'b0;
         tail_r     <= 1'b0;
      end
      else if (CE)
      begin
         if (init)
         begin
            state_r    <= ST_IDLE;
            bits_r     <= '0;
            tail_cnt_r <= '0;
            start_r    <= 1'b0;
            tail_r     <= 1'b0;
         end
         else
         begin
            case (state_r)
               ST_IDLE:
               begin
                  if (go)
                  begin
                     state_r <= ST_SHIFT;
                     bits_r  <= '0;
                     start_r <= 1'b1;
                  end
               end
               ST_SHIFT:
               begin
                  if (rise_ev)
                     bits_r <= bits_r + 5'h01;
                  if (word_done)
                  begin
                     start_r <= 1'b0;
                     if (ctrl_r.tail_mark_enable)
                     begin
                        state_r    <= ST_TAIL;
                        tail_r     <= 1'b1;
                        tail_cnt_r <= '0;
                     end
                     else
                        state_r <= ST_IDLE;
                  end
               end
               ST_TAIL:
               begin
                  if (tick)
                     tail_cnt_r <= tail_cnt_r + 4'h1;
                  if (tail_end)
                  begin
                     state_r <= ST_IDLE;
                     tail_r  <= 1'b0;
                  end
               end
               default:
               begin
                  state_r <= ST_IDLE;
                  start_r <= 1'b0;
                  tail_r  <= 1'b0;
               end
            endcase
         end
      end
   end

   // Serial clock, idles high, toggles only mid-word
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
         sck_r <= 1'b1;
      else if (CE)
      begin
         if (init || state_r != ST_SHIFT)
            sck_r <= 1'b1;
         else if (!ext_clk && tick)
            sck_r <= ~sck_r;
      end
   end

   // Shift register: LSB out, received bits enter at top
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
         sh_r <= '0;
      else if (CE)
      begin
         if (go)
            sh_r <= {dhi_r, dlo_r};
         else if (state_r == ST_SHIFT && rise_ev)
         begin
            if (ctrl_r.mode_low_bit)
               sh_r <= {si_s_r, sh_r[15:1]};
            else
               sh_r[7:0] <= {si_s_r, sh_r[7:1]};
         end
      end
   end

   // Data registers, reloaded with received word at completion
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
      begin
         dlo_r <= DATA_RST;
         dhi_r <= DATA_RST;
      end
      else if (CE)
      begin
         if (word_done)
         begin
            if (ctrl_r.mode_low_bit)
            begin
               dlo_r <= sh_r[8:1];
               dhi_r <= {si_s_r, sh_r[15:9]};
            end
            else
               dlo_r <= {si_s_r, sh_r[7:1]};
         end
         else if (DATA_WR && state_r == ST_IDLE)
         begin
            dlo_r <= DATA_LOW_IN;
            dhi_r <= DATA_HIGH_IN;
         end
      end
   end

   // Serial output level
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
         so_r <= LEVEL_RST;
      else if (CE)
      begin
         if (state_r == ST_SHIFT && fall_ev)
            so_r <= sh_r[0];
         else if (state_r == ST_TAIL)
            so_r <= (tail_cnt_r >= tail_len);
         else if (LEVEL_WR && state_r == ST_IDLE)
            so_r <= LEVEL_IN;
      end
   end

   // Done request; a new completion beats a clear
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
         req_r <= 1'b0;
      else if (CE)
      begin
         if (word_done)
            req_r <= 1'b1;
         else if (DONE_CLR)
            req_r <= 1'b0;
      end
   end

   // Overrun detect on external clock after completion
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
      begin
         ovr_r       <= 1'b0;
         ovr_armed_r <= 1'b0;
         done_once_r <= 1'b0;
      end
      else if (CE)
      begin
         if (init || go)
            done_once_r <= 1'b0;
         else if (word_done)
            done_once_r <= 1'b1;
         if (ext_clk && done_once_r && state_r == ST_IDLE
             && ext_rise)
         begin
            ovr_r       <= 1'b1;
            ovr_armed_r <= 1'b0;
         end
         else if (OVR_CLR_WR && ovr_armed_r)
         begin
            ovr_r       <= 1'b0;
            ovr_armed_r <= 1'b0;
         end
         else if (STATUS_RD && ovr_r)
            ovr_armed_r <= 1'b1;
      end
   end

   assign SCK_OUT         = sck_r;
   assign SCK_OE          = ~ext_clk;
   assign SO_OUT          = so_r;
   assign SO_OE           = OD_SEL ? ~so_r : 1'b1;
   assign CTRL_OUT        = ctrl_r;
   assign DATA_LOW_OUT    = dlo_r;
   assign DATA_HIGH_OUT   = dhi_r;
   assign DONE_REQ        = req_r;
   assign DONE_IRQ        = req_r & DONE_EN;
   assign STATUS.output_level_bit   = so_r;
   assign STATUS.overrun_error_flag = ovr_r;
   assign STATUS.tail_active_flag   = tail_r;
   assign STATUS.start_flag         = start_r;

endmodule

// ### verification/serial_tail_checker.sv
`timescale 1ns/10ps
module serial_tail_checker
   import serial_tail_pkg::*;
(
   input  wire logic  CLK_SYS,    // Clock
   input  wire logic  SRST,       // Reset
   input  wire logic  CE,         // Clock enable
   input  wire logic  CTRL_WR,    // Ctrl write
   input  wire ctrl_t CTRL_IN,    // Ctrl data
   input  wire logic  START_WR,   // Start write
   input  wire logic  LEVEL_WR,   // Level write
   input  wire logic  LEVEL_IN,   // Level value
   input  wire logic  OVR_CLR_WR, // Overrun clear
   input  wire logic  DONE_EN,    // Irq enable
   input  wire logic  OD_SEL,     // Open-drain
   input  wire logic  SCK_OUT,    // Clock out
   input  wire logic  SO_OUT,     // Data out
   input  wire logic  SO_OE,      // Data enable
   input  wire ctrl_t CTRL_OUT,   // Ctrl readback
   input  wire stat_t STATUS,     // Status
   input  wire logic  DONE_REQ,   // Done flag
   input  wire logic  DONE_IRQ    // Gated irq
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (SRST || !CE);
   logic idle;
   assign idle = !STATUS.start_flag && !STATUS.tail_active_flag;
   a_irq_gate: assert property (DONE_IRQ == (DONE_REQ && DONE_EN))
      else $error("irq gate wrong");
   a_od_enable: assert property (SO_OE == (OD_SEL ? !SO_OUT : 1'b1))
      else $error("data enable wrong");
   a_start_busy: assert property (START_WR && idle && !CTRL_WR
      && !CTRL_OUT.mode_high_bit |=> STATUS.start_flag)
      else $error("start not taken");
   a_done_set: assert property ($fell(STATUS.start_flag)
      && !$past(CTRL_WR) && !$past(SRST) |-> DONE_REQ)
      else $error("done not raised");
   a_idle_sck: assert property (idle && $past(idle) |-> SCK_OUT)
      else $error("clock moved idle");
   a_so_hold: assert property (idle && $past(idle) && !$past(SRST)
      && !$past(LEVEL_WR) && !$past(CTRL_WR) |-> $stable(SO_OUT))
      else $error("output moved idle");
   a_level_write: assert property (LEVEL_WR && idle && !CTRL_WR
      |=> SO_OUT == $past(LEVEL_IN))
      else $error("level not driven");
   a_tail_entry: assert property ($rose(STATUS.tail_active_flag)
      |-> !STATUS.start_flag && DONE_REQ)
      else $error("tail entry wrong");
   a_ctrl_init: assert property (CTRL_WR && !CTRL_IN.tail_mark_enable
      |=> idle)
      else $error("no init on write");
   a_ovr_clear: assert property ($fell(STATUS.overrun_error_flag)
      && !$past(SRST) |-> $past(OVR_CLR_WR))
      else $error("overrun lost");
endmodule
bind sync_serial_tail_mark_port serial_tail_checker i_serial_tail_checker
   (.*);

// ### verification/serial_peer.sv
`timescale 1ns/10ps
module serial_peer
(
   input  wire logic        sck,  // Line clock
   input  wire logic        sdo,  // Data from port
   input  wire logic        load, // Load reply
   input  wire logic [15:0] word, // Reply word
   output logic             sdi,  // Data to port
   output logic [15:0]      got   // Captured bits
);
   logic [15:0] tx_r = 16'h0000;
   logic        seen_r = 1'h0;
   initial got = 16'h0000;
   assign sdi = tx_r[0];
   always @(posedge sck or posedge load)
      if (load)
         seen_r <= 1'h0;
      else
      begin
         seen_r <= 1'h1;
         got <= {sdo, got[15:1]};
      end
   // Each used bit is replaced at the top by its complement
   always @(negedge sck or posedge load)
      if (load)
         tx_r <= word;
      else if (seen_r)
         tx_r <= {~tx_r[0], tx_r[15:1]};
endmodule

// ### verification/sync_serial_tail_mark_port_tb.sv
`timescale 1ns/10ps
module sync_serial_tail_mark_port_tb;
   import serial_tail_pkg::*;
   typedef struct {
      logic        ml;
      logic [2:0]  tap;
      logic [7:0]  lo;
      logic [7:0]  hi;
      logic [15:0] rep;
   } row_t;
   row_t rows [4] = '{'{1'h0, 3'h2, 8'hA5, 8'hFF, 16'h003C},
      '{1'h1, 3'h2, 8'hC3, 8'h5A, 16'h1234},
      '{1'h0, 3'h3, 8'h01, 8'h00, 16'h00FE},
      '{1'h1, 3'h4, 8'h80, 8'h7F, 16'hFFFF}};
   logic clk_sys = 1'h0, srst = 1'h1, ctrl_wr = 1'h0, data_wr = 1'h0;
   logic start_wr = 1'h0, level_wr = 1'h0, level_in = 1'h0;
   logic status_rd = 1'h0, ovr_clr_wr = 1'h0, done_clr = 1'h0;
   logic done_en = 1'h0, od_sel = 1'h0, ext_clk = 1'h1, pload = 1'h0;
   logic        ce = 1'h1;
   ctrl_t       ctrl_in = '0;
   ctrl_t       ctrl_out;
   stat_t       status;
   logic [7:0]  dl = 8'h00, dh = 8'h00, dlo, dhi;
   logic [15:0] pword = 16'h0000, pgot;
   logic        sck_out, sck_oe, so_out, so_oe, si, done_req, done_irq;
   int          err_count = 0, check_count = 0, low_n = 0;
   wire         sck_line = sck_oe ? sck_out : ext_clk;
   wire         so_line = so_oe ? so_out : 1'h1;
   always #2.5 clk_sys = ~clk_sys;
   sync_serial_tail_mark_port i_sync_serial_tail_mark_port (
      .CLK_SYS(clk_sys), .SRST(srst), .CE(ce), .CTRL_WR(ctrl_wr),
      .CTRL_IN(ctrl_in), .DATA_WR(data_wr), .DATA_LOW_IN(dl),
      .DATA_HIGH_IN(dh), .START_WR(start_wr), .LEVEL_WR(level_wr),
      .LEVEL_IN(level_in), .STATUS_RD(status_rd), .OVR_CLR_WR(ovr_clr_wr),
      .DONE_CLR(done_clr), .DONE_EN(done_en), .OD_SEL(od_sel),
      .SCK_IN(sck_line), .SCK_OUT(sck_out), .SCK_OE(sck_oe), .SI_IN(si),
      .SO_OUT(so_out), .SO_OE(so_oe), .CTRL_OUT(ctrl_out), .STATUS(status),
      .DATA_LOW_OUT(dlo), .DATA_HIGH_OUT(dhi), .DONE_REQ(done_req),
      .DONE_IRQ(done_irq));
   serial_peer i_serial_peer (.sck(sck_line), .sdo(so_line), .load(pload),
      .word(pword), .sdi(si), .got(pgot));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk_sys);
      s = 1'h1;
      @(negedge clk_sys);
      s = 1'h0;
   endtask
   task automatic cfg(input ctrl_t c);
      ctrl_in = c;
      pulse(ctrl_wr);
   endtask
   task automatic launch(input logic [7:0] lo, hi, input logic [15:0] rep);
      dl = lo;
      dh = hi;
      pword = rep;
      pulse(data_wr);
      pulse(pload);
      pulse(done_clr);
      pulse(start_wr);
   endtask
   task automatic wait_idle();
      for (int n = 0; n < 20000 && (status.start_flag !== 1'h0
           || status.tail_active_flag !== 1'h0); n++)
         @(negedge clk_sys);
   endtask
   task automatic ext_pulses(input int n);
      repeat (n)
      begin
         repeat (8) @(negedge clk_sys);
         ext_clk = 1'h0;
         repeat (8) @(negedge clk_sys);
         ext_clk = 1'h1;
      end
      repeat (8) @(negedge clk_sys);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (60000) @(posedge clk_sys);
      err_count++;
      results();
   end
   initial
   begin
      repeat (5) @(negedge clk_sys);
      srst = 1'h0;
      chk({status, so_out, sck_out, done_req}, 16'h0002);
      level_in = 1'h1;
      pulse(level_wr);
      chk(so_out, 1'h1);
      $display("test reset and level done");
      foreach (rows[i])
      begin
         cfg({1'h0, rows[i].ml, 3'h0, rows[i].tap});
         launch(rows[i].lo, rows[i].hi, rows[i].rep);
         wait_idle();
         chk({status.start_flag, done_req}, 2'h1);
         chk(dlo, rows[i].rep[7:0]);
         chk(dhi, rows[i].ml ? rows[i].rep[15:8] : rows[i].hi);
         chk(rows[i].ml ? pgot : pgot[15:8], rows[i].ml ?
             {rows[i].hi, rows[i].lo} : {8'h00, rows[i].lo});
         chk(so_out, rows[i].ml ? rows[i].hi[7] : rows[i].lo[7]);
         chk(sck_out, 1'h1);
      end
      chk(done_irq, 1'h0);
      done_en = 1'h1;
      @(negedge clk_sys);
      chk(done_irq, 1'h1);
      $display("test table done");
      cfg(8'h07);
      launch(8'h3C, 8'h00, 16'h0000);
      repeat (20) @(negedge clk_sys);
      chk(status.start_flag, 1'h1);
      ce = 1'h0;
      cfg(8'h07);
      chk(status.start_flag, 1'h1);
      ce = 1'h1;
      cfg(8'h07);
      chk(status.start_flag, 1'h0);
      cfg(8'h80);
      pulse(start_wr);
      chk(status.start_flag, 1'h0);
      $display("test init done");
      od_sel = 1'h1;
      for (int l = 0; l < 2; l++)
      begin
         pulse(level_wr);
         cfg({3'h1, l[0], 4'h7});
         launch(8'h96, 8'h00, 16'h0000);
         for (int n = 0; n < 20000 && status.tail_active_flag !== 1'h1; n++)
            @(negedge clk_sys);
         chk({status.start_flag, done_req}, 2'h1);
         chk(pgot[15:8], 8'h96);
         low_n = 0;
         for (int n = 0; n < 4000 && status.tail_active_flag === 1'h1; n++)
         begin
            @(negedge clk_sys);
            low_n += (so_line === 1'h0);
         end
         chk(16'(low_n), {3'h0, (l[0] ? TAIL_LATCH_SELECT_BIT_HP
             : TAIL_HOLD_HP), 9'h000});
         wait_idle();
         chk(so_line, 1'h1);
      end
      od_sel = 1'h0;
      $display("test tail done");
      cfg(8'h08);
      chk({ctrl_out, sck_oe}, 9'h010);
      launch(8'h5C, 8'h00, 16'h00A7);
      ext_pulses(8);
      chk({status.overrun_error_flag, pgot[15:8]}, 9'h05C);
      chk(dlo, 8'hA7);
      ext_pulses(1);
      chk({status.overrun_error_flag, dlo}, 9'h1A7);
      pulse(ovr_clr_wr);
      chk(status.overrun_error_flag, 1'h1);
      pulse(status_rd);
      pulse(ovr_clr_wr);
      chk(status.overrun_error_flag, 1'h0);
      $display("test external done");
      results();
   end
endmodule
